// ===== design/aeq_biquad.sv
// One filter section: direct form I biquad with saturation.
// Assumes the caller strobes one sample at a time on the shared clock.
`timescale 1ns/10ps
module aeq_biquad (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Sample in
    input wire logic stb_in,
    input wire logic en,
    input wire aeq_pkg::aeq_smp_t x,
    input wire aeq_pkg::aeq_coef_t coef,
    // Sample out, one cycle later
    output aeq_pkg::aeq_smp_t y,
    output logic stb_out
);
    aeq_pkg::aeq_sec_st_t q;
    aeq_pkg::aeq_sec_st_t d;
    logic signed [aeq_pkg::ACC_W-1:0] acc;
    logic signed [aeq_pkg::ACC_W-1:0] shr;

    always_comb begin
        d = q;
        d.stb = stb_in;
        acc = '0;
        shr = '0;
        if (stb_in && en) begin
            acc = aeq_pkg::ACC_W'(coef.b0) * aeq_pkg::ACC_W'(x)
                + aeq_pkg::ACC_W'(coef.b1) * aeq_pkg::ACC_W'(q.x1)
                + aeq_pkg::ACC_W'(coef.b2) * aeq_pkg::ACC_W'(q.x2)
                - aeq_pkg::ACC_W'(coef.a1) * aeq_pkg::ACC_W'(q.y1)
                - aeq_pkg::ACC_W'(coef.a2) * aeq_pkg::ACC_W'(q.y2);
            shr = acc >>> aeq_pkg::CF;
            // Clip rather than wrap: a wrapped sample is a full-scale click
            if (shr > aeq_pkg::ACC_W'(aeq_pkg::SMP_MAX)) begin
                d.y = aeq_pkg::SMP_MAX;
            end else if (shr < aeq_pkg::ACC_W'(aeq_pkg::SMP_MIN)) begin
                d.y = aeq_pkg::SMP_MIN;
            end else begin
                d.y = aeq_pkg::SW'(shr);
            end
            d.x2 = q.x1;
            d.x1 = x;
            d.y2 = q.y1;
            d.y1 = d.y;
        end else if (stb_in) begin
            // Disabled: pass unchanged and forget history so re-enabling starts clean
            d.y = x;
            d.x1 = '0;
            d.x2 = '0;
            d.y1 = '0;
            d.y2 = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign y = q.y;
    assign stb_out = q.stb;

    AST_SEC_LATENCY: assert property (@(posedge ref_clk) disable iff (!resetn)
        stb_in |=> (stb_out ##1 !stb_out or stb_out ##1 $past(stb_in)))
        else $error("section output strobe not one cycle after input");

    AST_SEC_PASS: assert property (@(posedge ref_clk) disable iff (!resetn)
        (stb_in && !en) |=> (y == $past(x) && stb_out))
        else $error("disabled section altered its sample");
endmodule

// ===== design/aeq_chain.sv
// Equalisation chain with 3-state PWM full-bridge and 2-state PWM half-bridge drive.
// Assumes parallel samples from a serial receiver on ref_clk; no register bus.
`timescale 1ns/10ps
module aeq_chain (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Samples from the serial receiver
    input wire aeq_pkg::aeq_pcm_t pcm_in,
    input wire aeq_pkg::aeq_width_t in_width,
    // Filter configuration
    input wire logic eq_global_bypass,
    input wire logic [aeq_pkg::NCH-1:0] chan_eq_bypass,
    input wire logic [aeq_pkg::NCH-1:0][aeq_pkg::NSEC-1:0] stage_en,
    input wire aeq_pkg::aeq_coef_t [aeq_pkg::NCH-1:0][aeq_pkg::NSEC-1:0] coef,
    // Power stage configuration
    input wire aeq_pkg::aeq_outcfg_t out_cfg,
    // Results
    output aeq_pkg::aeq_pcm_t eq_out,
    output aeq_pkg::aeq_bridge_t bridge
);
    // ****************************************
    // State
    // ****************************************
    aeq_pkg::aeq_chain_st_t q;
    aeq_pkg::aeq_chain_st_t d;

    logic [aeq_pkg::NCH-1:0][aeq_pkg::NSEC-1:0] en_eff;
    wire aeq_pkg::aeq_smp_t sec_x [aeq_pkg::NCH][aeq_pkg::NSEC+1];
    wire logic sec_s [aeq_pkg::NCH][aeq_pkg::NSEC+1];

    aeq_pkg::aeq_smp_t wmask;
    int wbits;
    aeq_pkg::aeq_smp_t src [aeq_pkg::NPWM];
    logic [aeq_pkg::SW-1:0] mag;
    logic [aeq_pkg::SW-1:0] ofs;
    logic [aeq_pkg::NPWM-1:0] pa;
    logic [aeq_pkg::NPWM-1:0] pb;
    logic [aeq_pkg::NPWM-1:0] hb;

    // ****************************************
    // Filter sections
    // ****************************************
    for (genvar c = 0; c < aeq_pkg::NCH; c++) begin : g_ch
        // Either bypass forces every stage of the channel to pass through
        assign en_eff[c] = stage_en[c]
            & {aeq_pkg::NSEC{~(eq_global_bypass | chan_eq_bypass[c])}};
        assign sec_x[c][0] = q.hold[c];
        assign sec_s[c][0] = q.tick;
        for (genvar k = 0; k < aeq_pkg::NSEC; k++) begin : g_sec
            aeq_biquad u_sec (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .stb_in(sec_s[c][k]),
                .en(en_eff[c][k]),
                .x(sec_x[c][k]),
                .coef(coef[c][k]),
                .y(sec_x[c][k+1]),
                .stb_out(sec_s[c][k+1])
            );
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        // Short words arrive MSB aligned; junk below the word is cleared
        unique case (in_width)
            aeq_pkg::AEQ_W16: wbits = aeq_pkg::WBITS16;
            aeq_pkg::AEQ_W18: wbits = aeq_pkg::WBITS18;
            aeq_pkg::AEQ_W20: wbits = aeq_pkg::WBITS20;
            aeq_pkg::AEQ_W24: wbits = aeq_pkg::SW;
        endcase
        wmask = aeq_pkg::aeq_smp_t'({aeq_pkg::SW{1'b1}} << (aeq_pkg::SW - wbits));

        // Zero-order hold resampler: latest sample is taken at each tick
        if (pcm_in.vld) begin
            d.hold[0] = pcm_in.left & wmask;
            d.hold[1] = pcm_in.right & wmask;
        end
        d.tick = 1'b0;
        if (q.div == aeq_pkg::DIV_W'(aeq_pkg::TICK_DIV - 1)) begin
            d.div = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + 1'b1;
        end

        d.res_vld = sec_s[0][aeq_pkg::NSEC];
        if (sec_s[0][aeq_pkg::NSEC]) begin
            d.res[0] = sec_x[0][aeq_pkg::NSEC];
            d.res[1] = sec_x[1][aeq_pkg::NSEC];
        end

        // One PWM frame per internal sample; duty is frozen for the frame
        if (q.pwm_cnt == aeq_pkg::DIV_W'(aeq_pkg::TICK_DIV - 1)) begin
            d.pwm_cnt = '0;
        end else begin
            d.pwm_cnt = q.pwm_cnt + 1'b1;
        end
        src[0] = q.res[0];
        src[1] = q.res[1];
        // Third channel is the mono sum for the bass bridge
        src[2] = aeq_pkg::aeq_smp_t'((aeq_pkg::SW+1)'(q.res[0])
            + (aeq_pkg::SW+1)'(q.res[1]) >>> 1);
        mag = '0;
        ofs = '0;
        for (int i = 0; i < aeq_pkg::NPWM; i++) begin
            pa[i] = q.pos[i] && (q.pwm_cnt < q.duty[i]);
            pb[i] = q.neg[i] && (q.pwm_cnt < q.duty[i]);
            hb[i] = q.pwm_cnt < q.hduty[i];
            if (q.pwm_cnt == '0) begin
                mag = src[i][aeq_pkg::SW-1] ? aeq_pkg::SW'(-src[i]) : src[i];
                ofs = {~src[i][aeq_pkg::SW-1], src[i][aeq_pkg::SW-2:0]};
                d.pos[i] = !src[i][aeq_pkg::SW-1] && (src[i] != '0);
                d.neg[i] = src[i][aeq_pkg::SW-1];
                d.duty[i] = aeq_pkg::DIV_W'((aeq_pkg::MW'(mag)
                    * aeq_pkg::MW'(aeq_pkg::TICK_DIV)) >> (aeq_pkg::SW - 1));
                d.hduty[i] = aeq_pkg::DIV_W'((aeq_pkg::MW'(ofs)
                    * aeq_pkg::MW'(aeq_pkg::TICK_DIV)) >> aeq_pkg::SW);
            end
        end

        // Unused code 11 falls back to the reset-default 2.1 arrangement
        unique case (out_cfg)
            aeq_pkg::AEQ_OUT_2FB: begin
                d.br = '{out1a: pa[0], out1b: pb[0], out2a: pa[1], out2b: pb[1]};
            end
            aeq_pkg::AEQ_OUT_1PFB: begin
                d.br = '{out1a: pa[2], out1b: pa[2], out2a: pb[2], out2b: pb[2]};
            end
            default: begin
                d.br = '{out1a: hb[0], out1b: hb[1], out2a: pa[2], out2b: pb[2]};
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign eq_out = '{left: q.res[0], right: q.res[1], vld: q.res_vld};
    assign bridge = q.br;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_byp_start;
        q.tick && eq_global_bypass;
    endsequence

    // Bypass must stand from the tick through the last section, else history mixes in
    sequence s_byp_held;
        s_byp_start ##1 eq_global_bypass [*8] ##1 eq_global_bypass;
    endsequence

    AST_TICK_RATE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (q.div == aeq_pkg::DIV_W'(aeq_pkg::TICK_DIV - 1)) |=> (q.tick && q.div == '0))
        else $error("sample tick not at end of divider period");

    AST_GLOBAL_BYPASS: assert property (@(posedge ref_clk) disable iff (!resetn)
        eq_global_bypass |-> (en_eff == '0))
        else $error("stage enabled under global bypass");

    AST_CHAN_BYPASS: assert property (@(posedge ref_clk) disable iff (!resetn)
        (chan_eq_bypass == 2'h1 && !eq_global_bypass)
            |-> (en_eff[0] == '0 && en_eff[1] == stage_en[1]))
        else $error("channel bypass leaked to the other channel");

    AST_STAGE_EN: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!eq_global_bypass && !chan_eq_bypass[0]) |-> (en_eff[0] == stage_en[0]))
        else $error("stage enable not followed");

    AST_BYPASS_PASS: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_byp_held |=> ##1 (eq_out.vld && eq_out.left == $past(q.hold[0], 11)
            && eq_out.right == $past(q.hold[1], 11)))
        else $error("bypassed sample changed");

    AST_TERNARY: assert property (@(posedge ref_clk) disable iff (!resetn)
        ($past(out_cfg) == aeq_pkg::AEQ_OUT_2FB)
            |-> !(bridge.out1a && bridge.out1b) && !(bridge.out2a && bridge.out2b))
        else $error("both sides of a bridge driven high");

    AST_PARALLEL: assert property (@(posedge ref_clk) disable iff (!resetn)
        ($past(out_cfg) == aeq_pkg::AEQ_OUT_1PFB)
            |-> (bridge.out1a == bridge.out1b && bridge.out2a == bridge.out2b))
        else $error("paralleled half bridges differ");

    AST_RESET_LOW: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(resetn) |-> (bridge == '0 && !eq_out.vld))
        else $error("output not low after reset");

    AST_RES_PULSE: assert property (@(posedge ref_clk) disable iff (!resetn)
        eq_out.vld |=> !eq_out.vld)
        else $error("result strobe longer than one cycle");

    AST_RES_LATENCY: assert property (@(posedge ref_clk) disable iff (!resetn)
        q.tick |-> ##11 eq_out.vld)
        else $error("result not eleven cycles after the tick");

    AST_WORD_MASK: assert property (@(posedge ref_clk) disable iff (!resetn)
        (pcm_in.vld && in_width == aeq_pkg::AEQ_W16)
            |=> (q.hold[0][aeq_pkg::SW-aeq_pkg::WBITS16-1:0] == '0
            && q.hold[1][aeq_pkg::SW-aeq_pkg::WBITS16-1:0] == '0))
        else $error("bits below a short word not cleared");

    AST_PWM_FRAME: assert property (@(posedge ref_clk) disable iff (!resetn)
        (q.pwm_cnt == aeq_pkg::DIV_W'(aeq_pkg::TICK_DIV - 1)) |=> (q.pwm_cnt == '0))
        else $error("PWM frame counter did not wrap at the frame end");
endmodule

// ===== inc/aeq_pkg.sv
// Shared constants and types of the equalisation chain.
// Assumes one 200 MHz clock; every file names items as aeq_pkg::name.
package aeq_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 200_000_000;
    localparam int FS_HZ = 96_000;
    // Clock cycles per internal sample, rounded down
    localparam int TICK_DIV = CLK_HZ / FS_HZ;
    localparam int DIV_W = 12;

    // ****************************************
    // Datapath geometry
    // ****************************************
    localparam int NCH = 2;
    localparam int NPWM = 3;
    localparam int SW = 24;
    localparam int CW = 28;
    // Coefficients are signed fractions with this many fraction bits
    localparam int CF = 26;
    localparam int ACC_W = 56;
    localparam int MW = SW + DIV_W;

    // Section order along each channel; the last four are user biquads
    localparam int SEC_PRESCALE = 0;
    localparam int SEC_DCBLOCK = 1;
    localparam int SEC_HIGHPASS = 2;
    localparam int SEC_DEEMPH = 3;
    localparam int SEC_BASS = 4;
    localparam int SEC_TREBLE = 5;
    localparam int SEC_USER0 = 6;
    localparam int NUSER = 4;
    localparam int NSEC = SEC_USER0 + NUSER;

    // Serial word widths
    localparam int WBITS16 = 16;
    localparam int WBITS18 = 18;
    localparam int WBITS20 = 20;

    // ****************************************
    // Types
    // ****************************************
    typedef logic signed [SW-1:0] aeq_smp_t;

    localparam aeq_smp_t SMP_MAX = 24'sh7fffff;
    localparam aeq_smp_t SMP_MIN = -24'sh800000;

    typedef enum logic [1:0] {
        AEQ_W16 = 2'b00,
        AEQ_W18 = 2'b01,
        AEQ_W20 = 2'b10,
        AEQ_W24 = 2'b11
    } aeq_width_t;

    typedef enum logic [1:0] {
        AEQ_OUT_2HB_1FB = 2'b00,
        AEQ_OUT_2FB = 2'b01,
        AEQ_OUT_1PFB = 2'b10
    } aeq_outcfg_t;

    typedef struct packed {
        logic signed [CW-1:0] b0;
        logic signed [CW-1:0] b1;
        logic signed [CW-1:0] b2;
        logic signed [CW-1:0] a1;
        logic signed [CW-1:0] a2;
    } aeq_coef_t;

    typedef struct packed {
        aeq_smp_t left;
        aeq_smp_t right;
        logic vld;
    } aeq_pcm_t;

    typedef struct packed {
        logic out1a;
        logic out1b;
        logic out2a;
        logic out2b;
    } aeq_bridge_t;

    typedef struct packed {
        aeq_smp_t x1;
        aeq_smp_t x2;
        aeq_smp_t y1;
        aeq_smp_t y2;
        aeq_smp_t y;
        logic stb;
    } aeq_sec_st_t;

    typedef struct packed {
        aeq_smp_t [NCH-1:0] hold;
        logic [DIV_W-1:0] div;
        logic tick;
        aeq_smp_t [NCH-1:0] res;
        logic res_vld;
        logic [DIV_W-1:0] pwm_cnt;
        logic [NPWM-1:0][DIV_W-1:0] duty;
        logic [NPWM-1:0][DIV_W-1:0] hduty;
        logic [NPWM-1:0] pos;
        logic [NPWM-1:0] neg;
        aeq_bridge_t br;
    } aeq_chain_st_t;
endpackage

// ===== testbench/aeq_partner.sv
// Partner model: parallel sample source ahead of the chain, power stage behind it.
// Assumes the bench calls its tasks; one clock shared with the chain.
`timescale 1ns/10ps
module aeq_partner (
    // Clock
    input wire logic ref_clk,
    // Source side
    output aeq_pkg::aeq_pcm_t pcm_in,
    // Power stage side
    input wire aeq_pkg::aeq_bridge_t bridge
);
    // ****************************************
    // Source
    // ****************************************
    initial pcm_in = '0;

    // Words come MSB aligned; after the strobe the data lines show the inverse, not stale data
    task automatic send(input aeq_pkg::aeq_smp_t l, input aeq_pkg::aeq_smp_t r);
        @(posedge ref_clk);
        pcm_in <= '{left: l, right: r, vld: 1'b1};
        @(posedge ref_clk);
        pcm_in <= '{left: ~l, right: ~r, vld: 1'b0};
    endtask

    // ****************************************
    // Power stage
    // ****************************************
    // High cycles of each pin over one full PWM frame
    task automatic count_frame(output int n[4]);
        n = '{0, 0, 0, 0};
        repeat (aeq_pkg::TICK_DIV) begin
            @(posedge ref_clk);
            #1;
            n[0] += int'(bridge.out1a);
            n[1] += int'(bridge.out1b);
            n[2] += int'(bridge.out2a);
            n[3] += int'(bridge.out2b);
        end
    endtask
endmodule

// ===== testbench/audio_eq_processing_chain_bench.sv
// Self-checking bench of the equalisation chain and its bridge drive.
// Assumes aeq_partner supplies samples and counts the bridge pins.
`timescale 1ns/10ps
module audio_eq_processing_chain_bench;
    // ****************************************
    // Signals
    // ****************************************
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    aeq_pkg::aeq_pcm_t pcm_in;
    aeq_pkg::aeq_width_t in_width = aeq_pkg::AEQ_W24;
    logic eq_global_bypass = 1'b0;
    logic [aeq_pkg::NCH-1:0] chan_eq_bypass = 2'h0;
    logic [aeq_pkg::NCH-1:0][aeq_pkg::NSEC-1:0] stage_en = 20'h0;
    aeq_pkg::aeq_coef_t [aeq_pkg::NCH-1:0][aeq_pkg::NSEC-1:0] coef = '0;
    aeq_pkg::aeq_outcfg_t out_cfg = aeq_pkg::AEQ_OUT_2HB_1FB;
    aeq_pkg::aeq_pcm_t eq_out;
    aeq_pkg::aeq_bridge_t bridge;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    aeq_chain uut (.ref_clk(ref_clk), .resetn(resetn), .pcm_in(pcm_in), .in_width(in_width),
        .eq_global_bypass(eq_global_bypass), .chan_eq_bypass(chan_eq_bypass),
        .stage_en(stage_en), .coef(coef), .out_cfg(out_cfg), .eq_out(eq_out), .bridge(bridge));
    aeq_partner partner (.ref_clk(ref_clk), .pcm_in(pcm_in), .bridge(bridge));

    initial forever #2.5 ref_clk = ~ref_clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Second result is taken: the first may still carry older data or config
    task automatic wait_res();
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                #1;
                n++;
            end while (eq_out.vld !== 1'b1 && n < 2200);
        end
        check(24'(n), 24'(aeq_pkg::TICK_DIV));
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_global();
        @(posedge ref_clk);
        eq_global_bypass <= 1'b1;
        stage_en <= 20'hfffff;
        in_width <= aeq_pkg::AEQ_W16;
        partner.send(24'h7f0f0f, 24'h0f0f0f);
        partner.send(24'h123456, 24'hfedcba);
        wait_res();
        check(eq_out.left, 24'h123400);
        check(eq_out.right, 24'hfedc00);
    endtask

    task automatic t_sat();
        aeq_pkg::aeq_coef_t [aeq_pkg::NCH-1:0][aeq_pkg::NSEC-1:0] c;
        c = '0;
        c[0][aeq_pkg::SEC_USER0].b0 = 28'hc000000;
        c[1][aeq_pkg::SEC_USER0 + 3].b0 = 28'hc000000;
        @(posedge ref_clk);
        eq_global_bypass <= 1'b0;
        in_width <= aeq_pkg::AEQ_W24;
        stage_en <= {10'h200, 10'h040};
        coef <= c;
        partner.send(24'h800000, 24'h000100);
        wait_res();
        check(eq_out.left, 24'h7fffff);
        check(eq_out.right, 24'hffff00);
    endtask

    task automatic t_chan();
        aeq_pkg::aeq_coef_t [aeq_pkg::NCH-1:0][aeq_pkg::NSEC-1:0] c;
        c = '0;
        c[1][aeq_pkg::SEC_PRESCALE].b0 = 28'h2000000;
        c[1][aeq_pkg::SEC_USER0 + 3].b0 = 28'hc000000;
        @(posedge ref_clk);
        chan_eq_bypass <= 2'h1;
        stage_en <= {10'h201, 10'h3ff};
        coef <= c;
        partner.send(24'h400000, 24'h400000);
        wait_res();
        check(eq_out.left, 24'h400000);
        check(eq_out.right, 24'he00000);
    endtask

    // Results left by t_chan: left +2^22, right -2^21, mono +2^20
    task automatic t_pwm();
        int n[4];
        int exp[4][4];
        exp = '{'{1562, 781, 260, 0}, '{1041, 0, 0, 520}, '{260, 260, 0, 0},
            '{1562, 781, 260, 0}};
        repeat (2 * aeq_pkg::TICK_DIV) @(posedge ref_clk);
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            out_cfg <= aeq_pkg::aeq_outcfg_t'(m[1:0]);
            repeat (2) @(posedge ref_clk);
            partner.count_frame(n);
            for (int k = 0; k < 4; k++) check(24'(n[k]), 24'(exp[m][k]));
        end
    endtask

    // Reset lands at an edge the flops still see high, so only an async clear passes
    task automatic t_mid_reset();
        for (int i = 0; i < 2100 && bridge.out1a !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        resetn <= 1'b0;
        #1;
        check({20'h0, bridge}, 24'h0);
        check(eq_out.left, 24'h0);
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        // First edge after release still shows the cleared outputs
        @(posedge ref_clk);
        #1;
        check({20'h0, bridge}, 24'h0);
        check({23'h0, eq_out.vld}, 24'h0);
    endtask

    // ****************************************
    // Sequence and watchdog
    // ****************************************
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        // Flops are unknown until the first edge under reset clears them
        @(posedge ref_clk);
        #1;
        check({20'h0, bridge}, 24'h0);
        check({23'h0, eq_out.vld}, 24'h0);
        @(posedge ref_clk);
        resetn <= 1'b1;
        t_global();
        t_sat();
        t_chan();
        t_pwm();
        t_mid_reset();
        close_out();
    end
endmodule
